/* File: hdl/bcc_pkg.sv */
// shared constants for the buck converter configuration registers
package bcc_pkg;
  // ==========================================================
  // register addresses
  localparam logic [15:0] BCC_ADDR_CONV2_CTL2 = 16'h405c;
  localparam logic [15:0] BCC_ADDR_CONV2_ON = 16'h405d;
  localparam logic [15:0] BCC_ADDR_CONV2_SLEEP = 16'h405e;
  localparam logic [15:0] BCC_ADDR_CONV2_SCALE = 16'h405f;
  localparam logic [15:0] BCC_ADDR_CONV3_CTL1 = 16'h4060;
  localparam logic [15:0] BCC_ADDR_USER_KEY = 16'h4008;
  // arbitrary unlock value
  localparam logic [15:0] BCC_USER_KEY_VALUE = 16'h9716;
  // ==========================================================
  // field positions
  localparam int BCC_SLOT_LSB = 13;
  localparam int BCC_MODE_LSB = 8;
  localparam int BCC_VHI_LSB = 2;
  localparam int BCC_SRC_LSB = 11;
  localparam int BCC_THR_LSB = 4;
  localparam int BCC_IND_BIT = 0;
  localparam int BCC_PHASE_BIT = 12;
  localparam int BCC_FLT_BIT = 7;
  localparam int BCC_SS_LSB = 4;
  localparam int BCC_LIM_LSB = 2;
  localparam int BCC_CAP_LSB = 0;
  // ==========================================================
  // reset values
  localparam logic [1:0] BCC_SS_RESET = 2'h1;
  localparam logic [1:0] BCC_LIM_RESET = 2'h1;
  localparam logic [1:0] BCC_CAP_RESET = 2'h0;
  // ==========================================================
  // voltage and current code mapping
  localparam logic [6:0] BCC_VCODE_MIN = 7'h08;
  localparam logic [6:0] BCC_VCODE_MAX = 7'h68;
  localparam logic [20:0] BCC_VMIN_UV = 21'd600000;
  localparam logic [20:0] BCC_VMAX_UV = 21'd1800000;
  localparam logic [20:0] BCC_VSTEP_UV = 21'd12500;
  localparam logic [11:0] BCC_THR_STEP_MA = 12'd250;
  localparam logic [8:0] BCC_LIM_BASE_MA = 9'd50;
  // ==========================================================
  // soft-start timing
  localparam real BCC_CLK_MHZ = 50.0;
  localparam real BCC_SS_T1_US = 512.0;
  localparam real BCC_SS_T2_MS = 4.096;
  localparam real BCC_SS_T3_MS = 32.768;
  localparam int BCC_SS_C1 = int'(BCC_SS_T1_US * BCC_CLK_MHZ);
  localparam int BCC_SS_C2 = int'(BCC_SS_T2_MS * 1000.0 * BCC_CLK_MHZ);
  localparam int BCC_SS_C3 = int'(BCC_SS_T3_MS * 1000.0 * BCC_CLK_MHZ);
  localparam int BCC_SS_STEPS = 3;
  localparam int BCC_SS_TW = 21;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    BCC_SS_IDLE = 3'b001,
    BCC_SS_STEP = 3'b010,
    BCC_SS_RUN = 3'b100
  } bcc_ss_state_t;
endpackage

/* File: hdl/bcc_ss_if.sv */
// soft-start request and progress between register bank and sequencer
`timescale 1ns/1ns
interface bcc_ss_if;
  logic start;
  logic [1:0] code;
  logic [1:0] step;
  logic done;
  modport bank (output start, output code, input step, input done);
  modport seq (input start, input code, output step, output done);
endinterface

/* File: hdl/bcc_softstart.sv */
// soft-start current limit step sequencer for the third converter
`timescale 1ns/1ns
module bcc_softstart import bcc_pkg::*; #(
  parameter int SS_C1 = BCC_SS_C1,
  parameter int SS_C2 = BCC_SS_C2,
  parameter int SS_C3 = BCC_SS_C3
) (
  input wire logic core_clk,
  input wire logic rst,
  bcc_ss_if.seq ss
);
  bcc_ss_state_t state_r;
  logic [BCC_SS_TW-1:0] timer_r;
  logic [BCC_SS_TW-1:0] len_nxt;
  logic [1:0] step_r;

  // code latched at start so a rewrite mid-ramp does not stretch a step
  logic [1:0] code_r;

  always_comb begin
    case (code_r)
      2'h1: len_nxt = BCC_SS_TW'(SS_C1 - 1);
      2'h2: len_nxt = BCC_SS_TW'(SS_C2 - 1);
      default: len_nxt = BCC_SS_TW'(SS_C3 - 1);
    endcase
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= BCC_SS_IDLE;
      timer_r <= '0;
      step_r <= 2'h0;
      code_r <= 2'h0;
    end else begin
      case (state_r)
        BCC_SS_IDLE: begin
          timer_r <= '0;
          step_r <= 2'h0;
          code_r <= ss.code;
          if (ss.start) begin
            if (ss.code == 2'h0) begin
              state_r <= BCC_SS_RUN;
              step_r <= 2'(BCC_SS_STEPS);
            end else begin
              state_r <= BCC_SS_STEP;
            end
          end
        end
        BCC_SS_STEP: begin
          if (!ss.start) begin
            // abort drops the step at once so the limit never lingers high
            state_r <= BCC_SS_IDLE;
            step_r <= 2'h0;
          end else if (timer_r == len_nxt) begin
            timer_r <= '0;
            step_r <= step_r + 2'h1;
            if (step_r == 2'(BCC_SS_STEPS - 1)) begin
              state_r <= BCC_SS_RUN;
            end
          end else begin
            timer_r <= timer_r + BCC_SS_TW'(1);
          end
        end
        BCC_SS_RUN: begin
          if (!ss.start) begin
            state_r <= BCC_SS_IDLE;
            step_r <= 2'h0;
          end
        end
        default: state_r <= BCC_SS_IDLE;
      endcase
    end
  end

  assign ss.step = step_r;
  assign ss.done = (state_r == BCC_SS_RUN);
endmodule

/* File: hdl/bcc_regs.sv */
// configuration register bank for the second and third buck converters
// Operation
// - threshold is 250 mA times code plus one
// - soft-start code zero starts immediately
// - other codes: three steps of set length
// - hysteretic limit 50 mA doubled per code
// - limit writes need unlocked user key
// - capacitor field loaded only from configuration
// - scaling source selects off, register, hardware
// - voltage codes 12.5 mV steps, clamped ends
// - sleep mode code decodes four modes
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module bcc_regs import bcc_pkg::*; #(
  parameter int SS_C1 = BCC_SS_C1,
  parameter int SS_C2 = BCC_SS_C2,
  parameter int SS_C3 = BCC_SS_C3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cfg_load,
  input wire logic [1:0] cfg_cap,
  input wire logic conv3_enable,
  input wire logic scaling_hw1,
  input wire logic scaling_hw2,
  output logic user_key_unlocked,
  output logic [11:0] conv2_high_current_threshold_ma,
  output logic conv2_high_current_indication_enable,
  output logic [2:0] conv2_on_timeslot,
  output logic [1:0] conv2_on_operating_mode,
  output logic [20:0] conv2_target_uv,
  output logic conv2_scaling_active,
  output logic [2:0] conv2_sleep_timeslot,
  output logic [3:0] conv2_sleep_mode_onehot,
  output logic [20:0] conv2_sleep_uv,
  output logic conv3_switching_phase,
  output logic conv3_fault_flag,
  output logic [8:0] conv3_hysteretic_limit_ma,
  output logic [1:0] conv3_cap_class,
  output logic [1:0] conv3_softstart_limit_step,
  output logic conv3_started
);
  // ==========================================================
  // voltage mapping
  // clamp ends, linear middle
  function automatic logic [20:0] bcc_code_to_uv(input logic [6:0] c);
    logic [20:0] d;
    d = {14'h0, c} - {14'h0, BCC_VCODE_MIN};
    if (c <= BCC_VCODE_MIN) begin
      bcc_code_to_uv = BCC_VMIN_UV;
    end else if (c >= BCC_VCODE_MAX) begin
      bcc_code_to_uv = BCC_VMAX_UV;
    end else begin
      bcc_code_to_uv = BCC_VMIN_UV + 21'(d * BCC_VSTEP_UV);
    end
  endfunction

  // ==========================================================
  // register storage
  logic [2:0] c2_thr_r;
  logic c2_ind_r;
  logic [2:0] c2_on_slot_r;
  logic [1:0] c2_on_mode_r;
  logic [4:0] c2_on_vhi_r;
  logic [1:0] c2_on_vlo_r;
  logic [2:0] c2_slp_slot_r;
  logic [1:0] c2_slp_mode_r;
  logic [6:0] c2_slp_vsel_r;
  logic [1:0] c2_src_r;
  logic [6:0] c2_dvs_vsel_r;
  logic c3_phase_r;
  logic c3_flt_r;
  logic [1:0] c3_ss_r;
  logic [1:0] c3_lim_r;
  logic [1:0] c3_cap_r;
  logic key_r;
  logic [6:0] c2_on_code;
  logic wr_ctl2;
  logic wr_on;
  logic wr_slp;
  logic wr_dvs;
  logic wr_c3;
  logic wr_key;

  assign wr_ctl2 = reg_wr && (reg_addr == BCC_ADDR_CONV2_CTL2);
  assign wr_on = reg_wr && (reg_addr == BCC_ADDR_CONV2_ON);
  assign wr_slp = reg_wr && (reg_addr == BCC_ADDR_CONV2_SLEEP);
  assign wr_dvs = reg_wr && (reg_addr == BCC_ADDR_CONV2_SCALE);
  assign wr_c3 = reg_wr && (reg_addr == BCC_ADDR_CONV3_CTL1);
  assign wr_key = reg_wr && (reg_addr == BCC_ADDR_USER_KEY);

  assign c2_on_code = {c2_on_vhi_r, c2_on_vlo_r};

  // ==========================================================
  // second converter registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c2_thr_r <= 3'h0;
      c2_ind_r <= 1'b0;
    end else if (wr_ctl2) begin
      c2_thr_r <= reg_wdata[BCC_THR_LSB +: 3];
      c2_ind_r <= reg_wdata[BCC_IND_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c2_on_slot_r <= 3'h0;
      c2_on_mode_r <= 2'h0;
      c2_on_vhi_r <= 5'h00;
      c2_on_vlo_r <= 2'h0;
    end else if (wr_on) begin
      c2_on_slot_r <= reg_wdata[BCC_SLOT_LSB +: 3];
      c2_on_mode_r <= reg_wdata[BCC_MODE_LSB +: 2];
      c2_on_vhi_r <= reg_wdata[BCC_VHI_LSB +: 5];
      c2_on_vlo_r <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c2_slp_slot_r <= 3'h0;
      c2_slp_mode_r <= 2'h0;
      c2_slp_vsel_r <= 7'h00;
    end else if (wr_slp) begin
      c2_slp_slot_r <= reg_wdata[BCC_SLOT_LSB +: 3];
      c2_slp_mode_r <= reg_wdata[BCC_MODE_LSB +: 2];
      c2_slp_vsel_r <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c2_src_r <= 2'h0;
      c2_dvs_vsel_r <= 7'h00;
    end else if (wr_dvs) begin
      c2_src_r <= reg_wdata[BCC_SRC_LSB +: 2];
      c2_dvs_vsel_r <= reg_wdata[6:0];
    end
  end

  // ==========================================================
  // user key and third converter control
  // any other value written to the key register locks again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      key_r <= 1'b0;
    end else if (wr_key) begin
      key_r <= (reg_wdata == BCC_USER_KEY_VALUE);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c3_phase_r <= 1'b0;
      c3_flt_r <= 1'b0;
      c3_ss_r <= BCC_SS_RESET;
    end else if (wr_c3) begin
      c3_phase_r <= reg_wdata[BCC_PHASE_BIT];
      c3_flt_r <= reg_wdata[BCC_FLT_BIT];
      c3_ss_r <= reg_wdata[BCC_SS_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c3_lim_r <= BCC_LIM_RESET;
    end else if (wr_c3 && key_r) begin
      c3_lim_r <= reg_wdata[BCC_LIM_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c3_cap_r <= BCC_CAP_RESET;
    end else if (cfg_load) begin
      c3_cap_r <= cfg_cap;
    end
  end

  // ==========================================================
  // read port, one cycle latency, unmapped reads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        BCC_ADDR_CONV2_CTL2: reg_rdata <= {9'h000, c2_thr_r, 3'h0, c2_ind_r};
        BCC_ADDR_CONV2_ON: reg_rdata <= {c2_on_slot_r, 3'h0, c2_on_mode_r, 1'b0, c2_on_code};
        BCC_ADDR_CONV2_SLEEP: reg_rdata <= {c2_slp_slot_r, 3'h0, c2_slp_mode_r, 1'b0, c2_slp_vsel_r};
        BCC_ADDR_CONV2_SCALE: reg_rdata <= {3'h0, c2_src_r, 4'h0, c2_dvs_vsel_r};
        BCC_ADDR_CONV3_CTL1: reg_rdata <= {3'h0, c3_phase_r, 4'h0, c3_flt_r, 1'b0, c3_ss_r, c3_lim_r, c3_cap_r};
        BCC_ADDR_USER_KEY: reg_rdata <= {15'h0000, key_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // decoded settings for the converter analog control
  logic scale_sel;
  always_comb begin
    case (c2_src_r)
      2'h1: scale_sel = 1'b1;
      2'h2: scale_sel = scaling_hw1;
      2'h3: scale_sel = scaling_hw2;
      default: scale_sel = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv2_scaling_active <= 1'b0;
      conv2_target_uv <= BCC_VMIN_UV;
      conv2_sleep_uv <= BCC_VMIN_UV;
    end else begin
      conv2_scaling_active <= scale_sel;
      conv2_target_uv <= bcc_code_to_uv(scale_sel ? c2_dvs_vsel_r : c2_on_code);
      conv2_sleep_uv <= bcc_code_to_uv(c2_slp_vsel_r);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv2_high_current_threshold_ma <= BCC_THR_STEP_MA;
      conv3_hysteretic_limit_ma <= BCC_LIM_BASE_MA << BCC_LIM_RESET;
      conv3_cap_class <= 2'h0;
      conv2_sleep_mode_onehot <= 4'h1;
    end else begin
      conv2_high_current_threshold_ma <= 12'({9'h000, c2_thr_r} + 12'h001) * BCC_THR_STEP_MA;
      conv3_hysteretic_limit_ma <= BCC_LIM_BASE_MA << c3_lim_r;
      conv3_cap_class <= (c3_cap_r == 2'h1) ? 2'h0 : c3_cap_r;
      conv2_sleep_mode_onehot <= 4'h1 << c2_slp_mode_r;
    end
  end

  assign user_key_unlocked = key_r;
  assign conv2_high_current_indication_enable = c2_ind_r;
  assign conv2_on_timeslot = c2_on_slot_r;
  assign conv2_on_operating_mode = c2_on_mode_r;
  assign conv2_sleep_timeslot = c2_slp_slot_r;
  assign conv3_switching_phase = c3_phase_r;
  assign conv3_fault_flag = c3_flt_r;

  // ==========================================================
  // soft-start sequencer
  bcc_ss_if ss();
  assign ss.start = conv3_enable;
  assign ss.code = c3_ss_r;
  assign conv3_softstart_limit_step = ss.step;
  assign conv3_started = ss.done;

  bcc_softstart #(
    .SS_C1(SS_C1),
    .SS_C2(SS_C2),
    .SS_C3(SS_C3)
  ) u_ss (
    .core_clk(core_clk),
    .rst(rst),
    .ss(ss)
  );
endmodule

/* File: verif/bcc_regs_assertions.sv */
// concurrent checks on the converter configuration register bank ports
`timescale 1ns/1ns
module bcc_regs_assertions import bcc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic cfg_load,
  input wire logic [1:0] cfg_cap,
  input wire logic conv3_enable,
  input wire logic user_key_unlocked,
  input wire logic [11:0] conv2_high_current_threshold_ma,
  input wire logic [3:0] conv2_sleep_mode_onehot,
  input wire logic [8:0] conv3_hysteretic_limit_ma,
  input wire logic [1:0] conv3_cap_class,
  input wire logic [1:0] conv3_softstart_limit_step,
  input wire logic conv3_started
);
  // ==========================================================
  // one clock domain, so clock and reset are shared
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // register side
  property p_thr;
    reg_wr && reg_addr == 16'h405c |-> ##2
      conv2_high_current_threshold_ma == 12'hfa * (12'($past(reg_wdata[6:4], 2)) + 12'h1);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode wrong");
  property p_lim_open;
    reg_wr && reg_addr == 16'h4060 && user_key_unlocked |-> ##2
      conv3_hysteretic_limit_ma == 9'h32 << $past(reg_wdata[3:2], 2);
  endproperty
  a_lim_open: assert property (p_lim_open) else $error("limit decode wrong");
  // a locked write must leave the limit untouched
  property p_lim_locked;
    reg_wr && reg_addr == 16'h4060 && !user_key_unlocked |-> ##2
      conv3_hysteretic_limit_ma == $past(conv3_hysteretic_limit_ma, 2);
  endproperty
  a_lim_locked: assert property (p_lim_locked) else $error("locked limit changed");
  property p_cap_hold;
    !cfg_load |-> ##2 $stable(conv3_cap_class);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("cap class moved without load");
  property p_cap_load;
    cfg_load |-> ##2 conv3_cap_class == ($past(cfg_cap, 2) == 2'h1 ? 2'h0 : $past(cfg_cap, 2));
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("cap class decode wrong");
  property p_mode_onehot;
    $onehot(conv2_sleep_mode_onehot);
  endproperty
  a_mode_onehot: assert property (p_mode_onehot) else $error("sleep mode not one-hot");
  // ==========================================================
  // soft-start side
  property p_ss_off;
    !conv3_enable |=> !conv3_started && conv3_softstart_limit_step == 2'h0;
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("soft-start not idle");
  property p_ss_full;
    conv3_started |-> conv3_softstart_limit_step == 2'h3;
  endproperty
  a_ss_full: assert property (p_ss_full) else $error("started below full step");
endmodule
bind bcc_regs bcc_regs_assertions u_bcc_regs_assertions (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .cfg_load, .cfg_cap, .conv3_enable, .user_key_unlocked, .conv2_high_current_threshold_ma,
  .conv2_sleep_mode_onehot, .conv3_hysteretic_limit_ma, .conv3_cap_class, .conv3_softstart_limit_step,
  .conv3_started);

/* File: verif/bcc_regs_tb.sv */
// self-checking bench for the converter configuration register bank
`timescale 1ns/1ns
module bcc_regs_tb import bcc_pkg::*;;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cfg_load = 0, en = 0, hw1 = 0, hw2 = 0;
  logic [15:0] addr = 16'h0, wd = 16'h0, rdata;
  logic [1:0] cfg_cap = 2'h0, cls, step, onmode;
  logic [11:0] thr;
  logic [20:0] tuv, suv;
  logic [3:0] oh;
  logic [8:0] lim;
  logic [2:0] ts, onslot;
  logic key, act, started, ind, ph, flt;
  int n_mismatch = 0, checked = 0;
  // short step times keep the ramps to a few dozen cycles
  bcc_regs #(.SS_C1(4), .SS_C2(8), .SS_C3(16)) u_bcc_regs (.core_clk(core_clk), .rst(rst),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .cfg_load(cfg_load), .cfg_cap(cfg_cap), .conv3_enable(en), .scaling_hw1(hw1), .scaling_hw2(hw2),
    .user_key_unlocked(key), .conv2_high_current_threshold_ma(thr), .conv2_high_current_indication_enable(ind),
    .conv2_on_timeslot(onslot), .conv2_on_operating_mode(onmode), .conv2_target_uv(tuv), .conv2_scaling_active(act),
    .conv2_sleep_timeslot(ts), .conv2_sleep_mode_onehot(oh), .conv2_sleep_uv(suv),
    .conv3_switching_phase(ph), .conv3_fault_flag(flt), .conv3_hysteretic_limit_ma(lim), .conv3_cap_class(cls),
    .conv3_softstart_limit_step(step), .conv3_started(started));
  initial forever #10 core_clk = ~core_clk;
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [20:0] g, e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // decoded outputs trail the field by one cycle
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // 0.6 V floor, 1.8 V ceiling, 12.5 mV steps
  function automatic logic [20:0] vuv(input int c);
    return c <= 8 ? 21'h927c0 : c >= 104 ? 21'h1b7740 : 21'h927c0 + 21'(c - 8) * 21'h30d4;
  endfunction
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(16'h4060, 16'h0014);
    rd(16'h4001, 16'h0000);
    chk(thr, 21'hfa);
    chk(tuv, 21'h927c0);
    chk(key, 21'h0);
  endtask
  task automatic t_thr;
    for (int c = 0; c < 8; c++) begin
      wr(16'h405c, 16'(c << 4 | c & 1));
      settle;
      chk(thr, 21'(12'hfa * (c + 1)));
      chk(ind, 21'(c & 1));
      rd(16'h405c, 16'(c << 4 | c & 1));
    end
  endtask
  task automatic t_key_lim;
    wr(16'h4060, 16'h108c);
    settle;
    chk(lim, 21'h64);
    chk({ph, flt}, 21'h3);
    rd(16'h4060, 16'h1084);
    wr(16'h4008, BCC_USER_KEY_VALUE);
    rd(16'h4008, 16'h0001);
    chk(key, 21'h1);
    for (int c = 0; c < 4; c++) begin
      wr(16'h4060, 16'(c << 2) | 16'h0013);
      settle;
      chk(lim, 21'(9'h32 << c));
      chk({ph, flt}, 21'h0);
      rd(16'h4060, 16'(c << 2) | 16'h0010);
    end
    wr(16'h4008, 16'h0000);
    wr(16'h4060, 16'h0010);
    settle;
    chk(key, 21'h0);
    chk(lim, 21'h190);
  endtask
  task automatic t_cap;
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      cfg_cap <= 2'(c);
      cfg_load <= 1'b1;
      @(posedge core_clk);
      cfg_load <= 1'b0;
      settle;
      chk(cls, c == 1 ? 21'h0 : 21'(c));
      rd(16'h4060, 16'h001c | 16'(c));
    end
  endtask
  task automatic t_volt;
    int v[6] = '{0, 8, 9, 103, 104, 127};
    foreach (v[i]) begin
      wr(16'h405d, 16'(i << 13 | (i & 3) << 8 | v[i]));
      settle;
      chk(tuv, vuv(v[i]));
      chk({onslot, onmode}, 21'(i << 2 | i & 3));
      rd(16'h405d, 16'(i << 13 | (i & 3) << 8 | v[i]));
    end
    for (int m = 0; m < 4; m++) begin
      wr(16'h405e, 16'(m << 13 | m << 8 | m * 40));
      settle;
      chk(oh, 21'(1 << m));
      chk(suv, vuv(m * 40));
      chk(ts, 21'(m));
    end
  endtask
  task automatic t_scale;
    bit e;
    wr(16'h405d, 16'h0009);
    for (int h = 0; h < 2; h++) begin
      hw1 <= 1'(h);
      hw2 <= 1'(1 - h);
      for (int s = 0; s < 4; s++) begin
        wr(16'h405f, 16'(s << 11) | 16'h0068);
        settle;
        e = s == 1 || s == 2 && h == 1 || s == 3 && h == 0;
        chk(act, 21'(e));
        chk(tuv, e ? 21'h1b7740 : vuv(9));
      end
    end
  endtask
  task automatic t_ss;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(16'h4060, 16'(c << 4));
      @(posedge core_clk);
      en <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk);
        #1 n++;
        if (c > 0 && started !== 1'b1) chk(step, 21'((n - 1) / (4 << (c - 1))));
      end while (started !== 1'b1 && n < 200);
      chk(21'(n), c == 0 ? 21'h1 : 21'(3 * (4 << (c - 1)) + 1));
      chk(step, 21'h3);
      @(posedge core_clk);
      en <= 1'b0;
      @(posedge core_clk);
    end
    // abort in mid-ramp must fall back to idle
    wr(16'h4060, 16'h0010);
    en <= 1'b1;
    repeat (6) @(posedge core_clk);
    en <= 1'b0;
    settle;
    chk({started, step}, 21'h0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_thr;
    t_key_lim;
    t_cap;
    t_volt;
    t_scale;
    t_ss;
    tally_and_finish;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
